// ### logic/imd_top.sv
// Integer multiply datapath: decoder requests in, register writes out.
// Assumes decoder holds request fields valid with req_valid.
//
// Contract
// - Pair forms write full product, high to next
// - All four operand signedness pairings supported, except file forms (both forced unsigned) and literal forms (second forced unsigned)
// - Single forms write one register only
// - Five-bit unsigned literal replaces second operand
// - Accumulator forms only on motor-control variants
// - Non-core register access adds one cycle
`timescale 1ns/100ps
`default_nettype none
module imd_top #(
  parameter bit MC_VARIANT = imd_pkg::MC_DEFAULT,
  parameter int ACC_WIDTH  = imd_pkg::ACC_W
) (
  input  wire logic                        core_clk,
  input  wire logic                        srst,
  input  wire logic                        req_valid,
  input  wire imd_pkg::imd_dest_e          req_dest,
  input  wire logic                        req_a_signed,
  input  wire logic                        req_b_signed,
  input  wire logic                        req_use_lit,
  input  wire logic [imd_pkg::DATA_W-1:0]  req_a,
  input  wire logic [imd_pkg::DATA_W-1:0]  req_b,
  input  wire logic [imd_pkg::LIT_W-1:0]   req_lit,
  input  wire logic [imd_pkg::IDX_W-1:0]   req_wnd,
  input  wire logic                        req_sfr_extra,
  output logic                             req_ready,
  output logic                             wr_lo_en,
  output logic [imd_pkg::IDX_W-1:0]        wr_lo_idx,
  output logic [imd_pkg::DATA_W-1:0]       wr_lo_data,
  output logic                             wr_hi_en,
  output logic [imd_pkg::IDX_W-1:0]        wr_hi_idx,
  output logic [imd_pkg::DATA_W-1:0]       wr_hi_data,
  output logic                             acc_en,
  output logic [ACC_WIDTH-1:0]             acc_data,
  output logic                             flags_we,
  output logic                             illegal_op
);
  import imd_pkg::*;

  imd_mul_if   mul ();
  imd_state_e  state_reg;
  logic        taken;
  logic        issue;
  logic [DATA_W-1:0] live_b;
  logic        live_as;
  logic        live_bs;
  logic [DATA_W-1:0] hold_a_reg;
  logic [DATA_W-1:0] hold_b_reg;
  logic        hold_as_reg;
  logic        hold_bs_reg;
  imd_dest_e   hold_dest_reg;
  logic [IDX_W-1:0] hold_wnd_reg;
  imd_dest_e   cur_dest;
  logic [IDX_W-1:0] cur_wnd;

  imd_mult u_mult (
    .mul (mul.core)
  );

  assign taken = req_valid && req_ready;
  assign issue = (taken && !req_sfr_extra) || (state_reg == IMD_ST_HOLD);

  // Literal is zero-extended and always unsigned
  assign live_b  = req_use_lit ? {{(DATA_W-LIT_W){1'b0}}, req_lit}
                               : req_b;
  assign live_as = (req_dest == IMD_DST_FILE) ? 1'b0 : req_a_signed;
  assign live_bs = (req_use_lit || req_dest == IMD_DST_FILE) ? 1'b0
                                                             : req_b_signed;

  // Held operands feed the multiplier during the extra cycle
  always_comb begin
    if (state_reg == IMD_ST_HOLD) begin
      mul.a        = hold_a_reg;
      mul.b        = hold_b_reg;
      mul.a_signed = hold_as_reg;
      mul.b_signed = hold_bs_reg;
      cur_dest     = hold_dest_reg;
      cur_wnd      = hold_wnd_reg;
    end else begin
      mul.a        = req_a;
      mul.b        = live_b;
      mul.a_signed = live_as;
      mul.b_signed = live_bs;
      cur_dest     = req_dest;
      cur_wnd      = req_wnd;
    end
  end

  // Sequencing and ready
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= IMD_ST_IDLE;
      req_ready <= 1'b1;
    end else if (state_reg == IMD_ST_HOLD) begin
      state_reg <= IMD_ST_IDLE;
      req_ready <= 1'b1;
    end else if (taken && req_sfr_extra) begin
      state_reg <= IMD_ST_HOLD;
      req_ready <= 1'b0;
    end
  end

  // Operand capture for stretched requests
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hold_a_reg    <= '0;
      hold_b_reg    <= '0;
      hold_as_reg   <= 1'b0;
      hold_bs_reg   <= 1'b0;
      hold_dest_reg <= IMD_DST_PAIR;
      hold_wnd_reg  <= '0;
    end else if (taken && req_sfr_extra) begin
      hold_a_reg    <= req_a;
      hold_b_reg    <= live_b;
      hold_as_reg   <= live_as;
      hold_bs_reg   <= live_bs;
      hold_dest_reg <= req_dest;
      hold_wnd_reg  <= req_wnd;
    end
  end

  // Result write-back
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_lo_en   <= 1'b0;
      wr_lo_idx  <= '0;
      wr_lo_data <= '0;
      wr_hi_en   <= 1'b0;
      wr_hi_idx  <= '0;
      wr_hi_data <= '0;
      acc_en     <= 1'b0;
      acc_data   <= '0;
      illegal_op <= 1'b0;
    end else begin
      wr_lo_en   <= 1'b0;
      wr_hi_en   <= 1'b0;
      acc_en     <= 1'b0;
      illegal_op <= 1'b0;
      if (issue) begin
        case (cur_dest)
          IMD_DST_PAIR: begin
            wr_lo_en   <= 1'b1;
            wr_lo_idx  <= cur_wnd;
            wr_lo_data <= mul.prod[DATA_W-1:0];
            wr_hi_en   <= 1'b1;
            wr_hi_idx  <= cur_wnd + PAIR_STEP;
            wr_hi_data <= mul.prod[2*DATA_W-1:DATA_W];
          end
          IMD_DST_SINGLE: begin
            wr_lo_en   <= 1'b1;
            wr_lo_idx  <= cur_wnd;
            wr_lo_data <= mul.prod[DATA_W-1:0];
          end
          IMD_DST_ACC: begin
            if (MC_VARIANT) begin
              acc_en   <= 1'b1;
              acc_data <= {{(ACC_WIDTH-PROD_W){mul.prod[PROD_W-1]}},
                           mul.prod};
            end else begin
              illegal_op <= 1'b1;
            end
          end
          default: begin
            wr_lo_en   <= 1'b1;
            wr_lo_idx  <= FILE_LO_IDX;
            wr_lo_data <= mul.prod[DATA_W-1:0];
            wr_hi_en   <= 1'b1;
            wr_hi_idx  <= FILE_HI_IDX;
            wr_hi_data <= mul.prod[2*DATA_W-1:DATA_W];
          end
        endcase
      end
    end
  end

  // Status flags are never written by this unit
  always_ff @(posedge core_clk) begin
    flags_we <= 1'b0;
  end

  // Reference product for checking
  function automatic logic [2*DATA_W-1:0] ref_prod(
    input logic [DATA_W-1:0] a,
    input logic [DATA_W-1:0] b,
    input logic              as,
    input logic              bs
  );
    logic signed [DATA_W:0]     ax;
    logic signed [DATA_W:0]     bx;
    logic signed [2*DATA_W+1:0] p;
    ax = $signed({as & a[DATA_W-1], a});
    bx = $signed({bs & b[DATA_W-1], b});
    p  = ax * bx;
    return p[2*DATA_W-1:0];
  endfunction : ref_prod

  logic [2*DATA_W-1:0] ref_now;
  logic                quick;
  assign ref_now = ref_prod(req_a, live_b, live_as, live_bs);
  assign quick   = taken && !req_sfr_extra;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_pair_write: assert property (
    quick && req_dest == IMD_DST_PAIR |=> wr_lo_en && wr_hi_en
      && wr_hi_idx == wr_lo_idx + PAIR_STEP && !flags_we)
    else $error("pair write malformed");
  a_sign_mix: assert property (
    quick && req_dest == IMD_DST_PAIR && !req_use_lit
      |=> {wr_hi_data, wr_lo_data} == $past(ref_now))
    else $error("signed product wrong");
  a_single_only: assert property (
    quick && req_dest == IMD_DST_SINGLE |=> wr_lo_en && !wr_hi_en
      && wr_lo_idx == $past(req_wnd))
    else $error("single form touched pair");
  a_lit_operand: assert property (
    quick && req_use_lit && req_dest == IMD_DST_PAIR
      |=> {wr_hi_data, wr_lo_data} == $past(ref_prod(req_a,
          {{(DATA_W-LIT_W){1'b0}}, req_lit}, req_a_signed, 1'b0)))
    else $error("literal product wrong");
  a_acc_gate: assert property (
    quick && req_dest == IMD_DST_ACC |=> (acc_en == MC_VARIANT)
      && (illegal_op == !MC_VARIANT))
    else $error("accumulator gating wrong");
  a_sfr_stall: assert property (
    taken && req_sfr_extra |=> !req_ready && !wr_lo_en && !acc_en
      ##1 req_ready && (wr_lo_en || acc_en || illegal_op))
    else $error("extra cycle missing");
  a_single_low: assert property (
    quick && req_dest == IMD_DST_SINGLE
      |=> wr_lo_data == $past(ref_now[DATA_W-1:0]))
    else $error("single low half wrong");
  a_one_cycle: assert property (
    quick |=> wr_lo_en || acc_en || illegal_op)
    else $error("result not in one cycle");

  c_pair: cover property (quick && req_dest == IMD_DST_PAIR);
  c_acc: cover property (quick && req_dest == IMD_DST_ACC ##1 acc_en);
  c_stall: cover property (taken && req_sfr_extra ##2 wr_lo_en);
  c_lit: cover property (quick && req_use_lit ##1 wr_lo_en);
endmodule : imd_top
`default_nettype wire

// ### include/imd_pkg.sv
// Constants and types of the integer multiply datapath.
// Assumes a 16-bit core with a 16-entry working register file.
`default_nettype none
package imd_pkg;
  localparam int          DATA_W      = 16;
  localparam int          PROD_W      = 33;
  localparam int          ACC_W       = 40;
  localparam int          LIT_W       = 5;
  localparam int          IDX_W       = 4;
  localparam logic [3:0]  FILE_LO_IDX = 4'h2;
  localparam logic [3:0]  FILE_HI_IDX = 4'h3;
  localparam logic [3:0]  PAIR_STEP   = 4'h1;
  localparam bit          MC_DEFAULT  = 1'b1;

  typedef enum logic [1:0] {
    IMD_DST_PAIR   = 2'h0,
    IMD_DST_SINGLE = 2'h1,
    IMD_DST_ACC    = 2'h2,
    IMD_DST_FILE   = 2'h3
  } imd_dest_e;

  typedef enum logic [0:0] {
    IMD_ST_IDLE = 1'h0,
    IMD_ST_HOLD = 1'h1
  } imd_state_e;
endpackage : imd_pkg
`default_nettype wire

// ### include/imd_mul_if.sv
// Operand and product bundle between datapath control and multiplier.
// Assumes both ends run combinationally in one clock domain.
`timescale 1ns/100ps
`default_nettype none
interface imd_mul_if;
  import imd_pkg::*;
  logic [DATA_W-1:0] a;
  logic [DATA_W-1:0] b;
  logic              a_signed;
  logic              b_signed;
  logic [PROD_W-1:0] prod;
  modport core (input a, input b, input a_signed, input b_signed,
                output prod);
  modport user (output a, output b, output a_signed, output b_signed,
                input prod);
endinterface : imd_mul_if
`default_nettype wire

// ### logic/imd_mult.sv
// Combinational 16x16 multiplier with per-operand signedness.
// Assumes operands are stable for the cycle they are used in.
`timescale 1ns/100ps
`default_nettype none
module imd_mult (
  imd_mul_if.core mul
);
  import imd_pkg::*;
  logic signed [DATA_W:0]     a_ext;
  logic signed [DATA_W:0]     b_ext;
  logic signed [2*DATA_W+1:0] full;

  // Extend each operand by its own sign choice
  assign a_ext = $signed({mul.a_signed & mul.a[DATA_W-1], mul.a});
  assign b_ext = $signed({mul.b_signed & mul.b[DATA_W-1], mul.b});
  assign full  = a_ext * b_ext;
  assign mul.prod = full[PROD_W-1:0];
endmodule : imd_mult
`default_nettype wire

// ### dv/imd_rf_model.sv
// Working register file model that takes the datapath write-backs.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module imd_rf_model (
  input wire logic                       core_clk,
  input wire logic                       srst,
  input wire logic                       lo_en,
  input wire logic [imd_pkg::IDX_W-1:0]  lo_idx,
  input wire logic [imd_pkg::DATA_W-1:0] lo_data,
  input wire logic                       hi_en,
  input wire logic [imd_pkg::IDX_W-1:0]  hi_idx,
  input wire logic [imd_pkg::DATA_W-1:0] hi_data
);
  import imd_pkg::*;
  logic [DATA_W-1:0] regs [16];
  // Fill value marks registers never written
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < 16; i++) begin
        regs[i] <= 16'hA5A5;
      end
    end else begin
      if (lo_en) begin
        regs[lo_idx] <= lo_data;
      end
      if (hi_en) begin
        regs[hi_idx] <= hi_data;
      end
    end
  end
endmodule : imd_rf_model
`default_nettype wire

// ### dv/integer_multiply_datapath_tb.sv
// Self-checking bench of the multiply datapath.
// Assumes imd_top and the register file model alongside.
`timescale 1ns/100ps
`default_nettype none
module integer_multiply_datapath_tb;
  import imd_pkg::*;
  typedef struct packed {
    imd_dest_e   d;
    logic        as;
    logic        bs;
    logic        ul;
    logic [15:0] a;
    logic [15:0] b;
    logic [3:0]  w;
    logic [39:0] e;
  } imd_row_s;
  // Expected value: exact product, sign-extended to 40 bits
  localparam imd_row_s ROWS [14] = '{
    '{IMD_DST_PAIR,   1'h1, 1'h1, 1'h0, 16'hFFFE, 16'h0003, 4'h4,
      40'hFFFFFFFFFA},
    '{IMD_DST_PAIR,   1'h1, 1'h0, 1'h0, 16'hFFFF, 16'hFFFF, 4'h2,
      40'hFFFFFF0001},
    '{IMD_DST_PAIR,   1'h0, 1'h1, 1'h0, 16'hFFFF, 16'h8000, 4'h0,
      40'hFF80008000},
    '{IMD_DST_PAIR,   1'h0, 1'h0, 1'h0, 16'hFFFF, 16'hFFFF, 4'hA,
      40'h00FFFE0001},
    '{IMD_DST_SINGLE, 1'h1, 1'h1, 1'h0, 16'h8000, 16'h8000, 4'h7,
      40'h0040000000},
    '{IMD_DST_SINGLE, 1'h1, 1'h0, 1'h0, 16'h1234, 16'hF00F, 4'h7,
      40'h001111D10C},
    '{IMD_DST_SINGLE, 1'h0, 1'h1, 1'h0, 16'hF234, 16'hF00F, 4'h7,
      40'hFFF0EAF10C},
    '{IMD_DST_SINGLE, 1'h0, 1'h0, 1'h0, 16'hFFFF, 16'hFFFF, 4'h7,
      40'h00FFFE0001},
    '{IMD_DST_PAIR,   1'h1, 1'h1, 1'h1, 16'h8001, 16'h001F, 4'hF,
      40'hFFFFF0801F},
    '{IMD_DST_SINGLE, 1'h0, 1'h1, 1'h1, 16'hABCD, 16'h0011, 4'h5,
      40'h00000B689D},
    '{IMD_DST_ACC,    1'h1, 1'h1, 1'h0, 16'h8000, 16'h7FFF, 4'h0,
      40'hFFC0008000},
    '{IMD_DST_ACC,    1'h0, 1'h0, 1'h0, 16'hFFFF, 16'hFFFF, 4'h0,
      40'h00FFFE0001},
    '{IMD_DST_ACC,    1'h1, 1'h1, 1'h1, 16'hFFF0, 16'h001F, 4'h0,
      40'hFFFFFFFE10},
    '{IMD_DST_FILE,   1'h1, 1'h1, 1'h0, 16'hFFFF, 16'hFFFF, 4'h9,
      40'h00FFFE0001}};
  localparam imd_row_s SR =
    '{IMD_DST_PAIR, 1'h0, 1'h0, 1'h0, 16'h0003, 16'h0005, 4'h1,
      40'h000000000F};
  logic        core_clk      = 1'b0;
  logic        srst          = 1'b1;
  logic        req_valid     = 1'b0;
  imd_dest_e   req_dest      = IMD_DST_PAIR;
  logic        req_a_signed  = 1'b0;
  logic        req_b_signed  = 1'b0;
  logic        req_use_lit   = 1'b0;
  logic [15:0] req_a         = 16'h0000;
  logic [15:0] req_b         = 16'h0000;
  logic [4:0]  req_lit       = 5'h00;
  logic [3:0]  req_wnd       = 4'h0;
  logic        req_sfr_extra = 1'b0;
  logic        req_ready;
  logic        wr_lo_en;
  logic [3:0]  wr_lo_idx;
  logic [15:0] wr_lo_data;
  logic        wr_hi_en;
  logic [3:0]  wr_hi_idx;
  logic [15:0] wr_hi_data;
  logic        acc_en;
  logic [39:0] acc_data;
  logic        flags_we;
  logic        illegal_op;
  logic        n_acc;
  logic        n_ill;
  int          miscompares   = 0;
  int          checked       = 0;
  int          cycles        = 0;
  imd_top uut (
    .core_clk (core_clk), .srst (srst), .req_valid (req_valid),
    .req_dest (req_dest), .req_a_signed (req_a_signed),
    .req_b_signed (req_b_signed), .req_use_lit (req_use_lit),
    .req_a (req_a), .req_b (req_b), .req_lit (req_lit),
    .req_wnd (req_wnd), .req_sfr_extra (req_sfr_extra),
    .req_ready (req_ready), .wr_lo_en (wr_lo_en),
    .wr_lo_idx (wr_lo_idx), .wr_lo_data (wr_lo_data),
    .wr_hi_en (wr_hi_en), .wr_hi_idx (wr_hi_idx),
    .wr_hi_data (wr_hi_data), .acc_en (acc_en), .acc_data (acc_data),
    .flags_we (flags_we), .illegal_op (illegal_op));
  imd_top #(.MC_VARIANT(1'b0)) uut_nmc (
    .core_clk (core_clk), .srst (srst), .req_valid (req_valid),
    .req_dest (req_dest), .req_a_signed (req_a_signed),
    .req_b_signed (req_b_signed), .req_use_lit (req_use_lit),
    .req_a (req_a), .req_b (req_b), .req_lit (req_lit),
    .req_wnd (req_wnd), .req_sfr_extra (req_sfr_extra),
    .req_ready (), .wr_lo_en (), .wr_lo_idx (), .wr_lo_data (),
    .wr_hi_en (), .wr_hi_idx (), .wr_hi_data (), .acc_en (n_acc),
    .acc_data (), .flags_we (), .illegal_op (n_ill));
  imd_rf_model rf (.core_clk (core_clk), .srst (srst),
    .lo_en (wr_lo_en), .lo_idx (wr_lo_idx), .lo_data (wr_lo_data),
    .hi_en (wr_hi_en), .hi_idx (wr_hi_idx), .hi_data (wr_hi_data));
  always #5 core_clk = ~core_clk;
  task automatic close_out();
    if (miscompares == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic chk(input string n, input logic [39:0] s,
                     input logic [39:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic drive(input imd_row_s r);
    req_valid    <= 1'b1;
    req_dest     <= r.d;
    req_a_signed <= r.as;
    req_b_signed <= r.bs;
    req_use_lit  <= r.ul;
    req_a        <= r.a;
    req_b        <= r.ul ? ~r.b : r.b;
    req_lit      <= r.b[4:0];
    req_wnd      <= r.w;
  endtask : drive
  task automatic chkrow(input imd_row_s r);
    logic [3:0]  lo_i;
    logic [3:0]  hi_i;
    lo_i = (r.d == IMD_DST_FILE) ? FILE_LO_IDX : r.w;
    hi_i = lo_i + PAIR_STEP;
    chk("flags_we", flags_we, 1'b0);
    chk("illegal", illegal_op, 1'b0);
    chk("nmc_ill", n_ill, r.d == IMD_DST_ACC);
    chk("nmc_acc", n_acc, 1'b0);
    if (r.d == IMD_DST_ACC) begin
      chk("acc_en", acc_en, 1'b1);
      chk("acc_data", acc_data, r.e);
      chk("lo_en", wr_lo_en, 1'b0);
    end else begin
      chk("lo_en", wr_lo_en, 1'b1);
      chk("lo_idx", wr_lo_idx, lo_i);
      chk("lo_data", wr_lo_data, r.e[15:0]);
      chk("hi_en", wr_hi_en, r.d != IMD_DST_SINGLE);
      if (r.d != IMD_DST_SINGLE) begin
        chk("hi_idx", wr_hi_idx, hi_i);
        chk("hi_data", wr_hi_data, r.e[31:16]);
      end
    end
  endtask : chkrow
  initial begin
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    #1;
    chk("ready", req_ready, 1'b1);
    chk("lo_en", wr_lo_en, 1'b0);
    chk("acc_en", acc_en, 1'b0);
    for (int i = 0; i < 14; i++) begin
      @(posedge core_clk);
      drive(ROWS[i]);
      #1;
      if (i > 0) begin
        chkrow(ROWS[i-1]);
      end
    end
    @(posedge core_clk);
    req_valid <= 1'b0;
    #1;
    chkrow(ROWS[13]);
    chk("rf_adjacent", rf.regs[8], 16'hA5A5);
    @(posedge core_clk);
    drive(SR);
    req_sfr_extra <= 1'b1;
    @(posedge core_clk);
    // New request during the stall must be refused, then taken
    drive(ROWS[0]);
    req_sfr_extra <= 1'b0;
    #1;
    chk("ready", req_ready, 1'b0);
    chk("lo_en", wr_lo_en, 1'b0);
    @(posedge core_clk);
    #1;
    chkrow(SR);
    chk("ready", req_ready, 1'b1);
    @(posedge core_clk);
    req_valid <= 1'b0;
    #1;
    chkrow(ROWS[0]);
    // Mid-run reset with a request standing at the reset edge
    @(posedge core_clk);
    srst <= 1'b1;
    drive(ROWS[3]);
    #1;
    chk("lo_en", wr_lo_en, 1'b0);
    @(posedge core_clk);
    srst      <= 1'b0;
    req_valid <= 1'b0;
    #1;
    chk("ready", req_ready, 1'b1);
    chk("lo_en", wr_lo_en, 1'b0);
    chk("hi_en", wr_hi_en, 1'b0);
    chk("lo_data", wr_lo_data, 16'h0000);
    chk("hi_data", wr_hi_data, 16'h0000);
    chk("lo_idx", wr_lo_idx, 4'h0);
    close_out();
  end
endmodule : integer_multiply_datapath_tb
`default_nettype wire
